// file: core/wlfs_pkg.sv
// wlfs_pkg: offsets, field positions and reset values of the wake, level,
// high-side fault and identification status group.
// assumes 7-bit register addresses and 8-bit register data.
package wlfs_pkg;
   // register offsets
   localparam logic [6:0] pin_wake_source_status_addr = 7'h47;
   localparam logic [6:0] input_level_status_addr = 7'h48;
   localparam logic [6:0] switch_overload_status_addr = 7'h54;
   localparam logic [6:0] switch_open_load_status_addr = 7'h55;
   localparam logic [6:0] device_identification_addr = 7'h7e;

   // pin wake source fields
   localparam int pin1_wake_flag_pos = 4;
   localparam int pin2_wake_flag_pos = 5;

   // input level fields
   localparam int development_mode_status_pos = 7;
   localparam int pullup_config_status_pos = 6;
   localparam int pin2_level_pos = 5;
   localparam int pin1_level_pos = 4;
   localparam int wake_input_level_lsb = 0;

   // high-side fault fields, switch 1 in the low bit
   localparam int switch_flag_lsb = 0;

   // identification fields
   localparam int product_line_code_lsb = 4;
   localparam int part_variant_code_lsb = 0;

   // reset values
   localparam logic [7:0] flag_reg_reset = 8'h00;
   localparam logic [7:0] level_reg_reset = 8'h00;
   localparam logic [7:0] unmapped_read_value = 8'h00;
endpackage : wlfs_pkg

// file: core/wlfs_flag_bank.sv
// wlfs_flag_bank: a row of sticky hardware-set, host-cleared flags.
// assumes set and clear are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
module wlfs_flag_bank #(
   parameter int width = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic soft_clear,
   input wire logic [width-1:0] set_in,
   input wire logic clr_in,
   output logic [width-1:0] flags
);
   logic [width-1:0] next_flags;

   // set beats clear so an event landing on the clear cycle survives
   always_comb begin
      if (soft_clear) begin
         next_flags = '0;
      end else begin
         next_flags = (flags & ~{width{clr_in}}) | set_in;
      end
   end

   // only power-on, soft reset and a host clear clear them; a restart leaves the flags alone
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end
endmodule : wlfs_flag_bank

// file: core/wlfs_status_regs.sv
// wlfs_status_regs: wake source, input level, high-side fault and
// identification status registers behind the command port.
// assumes the command decoder gives one-cycle read and read-clear strobes
// and that every event and level input is synchronous to clk.
`timescale 1ns/1ps

// Contract
// - pin 2 wake sets bit 5, pin 1 wake sets bit 4 of wake source
// - reserved bits always read zero
// - level bit 7 shows the latched test-pin operating mode
// - level bit 6 shows the interrupt-pin pull-up strap
// - level bits 5,4 show pins 2,1; bits 2..0 show wake inputs 3..1
// - pin levels refresh in Normal and Stop when configured wake/switch
// - cyclic wake inputs hold the last sample, updated each sampling
// - general pins never use cyclic sampling
// - a general pin level shows even when used as a switch
// - one overload flag per switch, switches 1..4 in bits 0..3
// - one open-load flag per switch, switches 1..4 in bits 0..3
// - fault flags clear on power-on or soft reset, kept over restart
// - identification bits 7:4 hold the fixed product line code
// - identification bits 3:0 hold the fixed part variant code
// - variant code returns to its constant after any reset or restart
// - the device never clears flags itself; the host clears them
// - a wake from fail-safe also sets the source flag
module wlfs_status_regs #(
   parameter logic [3:0] product_line_code = 4'h5, // arbitrary value
   parameter logic [3:0] part_variant_code = 4'ha // arbitrary value
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic soft_reset,
   input wire logic restart,
   input wire logic reg_rd,
   input wire logic reg_clr,
   input wire logic [6:0] reg_addr,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [1:0] pin_wake_event,
   input wire logic [1:0] failsafe_pin_wake,
   input wire logic fail_output3_test_pin,
   input wire logic pullup_strap,
   input wire logic [1:0] pin_level_in,
   input wire logic [1:0] pin_selected,
   input wire logic [1:0] pin_configured,
   input wire logic normal_or_stop,
   input wire logic [2:0] wake_level_in,
   input wire logic [2:0] wake_cyclic,
   input wire logic [2:0] wake_sample_done,
   input wire logic [3:0] overload_event,
   input wire logic [3:0] open_load_event
);
   logic [1:0] pin_wake;
   logic [3:0] overload_flags;
   logic [3:0] open_load_flags;
   logic strap_pending;
   logic next_strap_pending;
   logic development_mode_status;
   logic next_development_mode_status;
   logic pullup_config_status;
   logic next_pullup_config_status;
   logic [1:0] pin_level;
   logic [1:0] next_pin_level;
   logic [2:0] wake_level;
   logic [2:0] next_wake_level;
   logic [7:0] next_reg_rdata;
   logic next_reg_rvalid;
   logic [7:0] level_word;
   logic [7:0] wake_word;
   logic [7:0] id_word;

   // read-clear decode, used for three registers
   function automatic logic clr_hit(input logic clr, input logic [6:0] a,
                                    input logic [6:0] target);
      clr_hit = clr && (a == target);
   endfunction : clr_hit

   // wake source flags, fail-safe wakes merged in
   wlfs_flag_bank #(.width(2)) u_wake (
      .clk(clk),
      .rst(rst),
      .soft_clear(soft_reset),
      .set_in(pin_wake_event | failsafe_pin_wake),
      .clr_in(clr_hit(reg_clr, reg_addr, wlfs_pkg::pin_wake_source_status_addr)),
      .flags(pin_wake)
   );

   // overload flags
   wlfs_flag_bank #(.width(4)) u_overload (
      .clk(clk),
      .rst(rst),
      .soft_clear(soft_reset),
      .set_in(overload_event),
      .clr_in(clr_hit(reg_clr, reg_addr, wlfs_pkg::switch_overload_status_addr)),
      .flags(overload_flags)
   );

   // open-load flags
   wlfs_flag_bank #(.width(4)) u_open_load (
      .clk(clk),
      .rst(rst),
      .soft_clear(soft_reset),
      .set_in(open_load_event),
      .clr_in(clr_hit(reg_clr, reg_addr, wlfs_pkg::switch_open_load_status_addr)),
      .flags(open_load_flags)
   );

   // straps are caught by a clocked capture after reset release, never
   // inside the async reset branch; a soft reset re-arms the capture
   always_comb begin
      next_strap_pending = strap_pending;
      next_development_mode_status = development_mode_status;
      next_pullup_config_status = pullup_config_status;
      if (soft_reset) begin
         next_strap_pending = 1'b1;
      end else if (strap_pending) begin
         next_strap_pending = 1'b0;
         next_development_mode_status = fail_output3_test_pin;
         next_pullup_config_status = pullup_strap;
      end
   end

   // levels: general pins follow the pin only while enabled, never sampled
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (normal_or_stop && pin_selected[i] && pin_configured[i]) begin
            next_pin_level[i] = pin_level_in[i];
         end else begin
            next_pin_level[i] = pin_level[i];
         end
      end
      for (int i = 0; i < 3; i++) begin
         if (!wake_cyclic[i] || wake_sample_done[i]) begin
            next_wake_level[i] = wake_level_in[i];
         end else begin
            next_wake_level[i] = wake_level[i];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_pending <= 1'b1;
         development_mode_status <= 1'b0;
         pullup_config_status <= 1'b0;
         pin_level <= 2'h0;
         wake_level <= 3'h0;
      end else begin
         strap_pending <= next_strap_pending;
         development_mode_status <= next_development_mode_status;
         pullup_config_status <= next_pullup_config_status;
         pin_level <= next_pin_level;
         wake_level <= next_wake_level;
      end
   end

   // register images; unassigned positions are constant zero
   always_comb begin
      wake_word = 8'h00;
      wake_word[wlfs_pkg::pin1_wake_flag_pos] = pin_wake[0];
      wake_word[wlfs_pkg::pin2_wake_flag_pos] = pin_wake[1];
      level_word = wlfs_pkg::level_reg_reset;
      level_word[wlfs_pkg::development_mode_status_pos] = development_mode_status;
      level_word[wlfs_pkg::pullup_config_status_pos] = pullup_config_status;
      level_word[wlfs_pkg::pin2_level_pos] = pin_level[1];
      level_word[wlfs_pkg::pin1_level_pos] = pin_level[0];
      level_word[wlfs_pkg::wake_input_level_lsb +: 3] = wake_level;
      // restart touches nothing here, so the id is always the constant
      id_word = {product_line_code, part_variant_code};
   end

   // read path: data registered, valid one cycle after the strobe
   always_comb begin
      next_reg_rvalid = reg_rd;
      next_reg_rdata = reg_rdata;
      if (reg_rd) begin
         unique case (reg_addr)
            wlfs_pkg::pin_wake_source_status_addr: next_reg_rdata = wake_word;
            wlfs_pkg::input_level_status_addr: next_reg_rdata = level_word;
            wlfs_pkg::switch_overload_status_addr:
               next_reg_rdata = {4'h0, overload_flags};
            wlfs_pkg::switch_open_load_status_addr:
               next_reg_rdata = {4'h0, open_load_flags};
            wlfs_pkg::device_identification_addr: next_reg_rdata = id_word;
            default: next_reg_rdata = wlfs_pkg::unmapped_read_value;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= wlfs_pkg::flag_reg_reset;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata <= next_reg_rdata;
         reg_rvalid <= next_reg_rvalid;
      end
   end

   // checks
   property p_pin_wake_sets;
      @(posedge clk) disable iff (rst)
         (pin_wake_event[1] || failsafe_pin_wake[1]) && !soft_reset |=> pin_wake[1];
   endproperty
   a_pin_wake_sets: assert property (p_pin_wake_sets)
      else $error("pin 2 wake did not set its flag");

   // both fault registers keep their upper nibble clear whatever the flags hold
   property p_reserved_zero;
      @(posedge clk) disable iff (rst)
         reg_rd && (reg_addr == wlfs_pkg::switch_overload_status_addr ||
                    reg_addr == wlfs_pkg::switch_open_load_status_addr)
         |=> reg_rdata[7:4] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved fault bits not zero");

   property p_wake_reserved;
      @(posedge clk) disable iff (rst)
         reg_rd && reg_addr == wlfs_pkg::pin_wake_source_status_addr
         |=> (reg_rdata & 8'hcf) == 8'h00;
   endproperty
   a_wake_reserved: assert property (p_wake_reserved)
      else $error("reserved wake source bits not zero");

   property p_strap_mode;
      @(posedge clk) disable iff (rst)
         strap_pending && !soft_reset |=> development_mode_status == $past(fail_output3_test_pin);
   endproperty
   a_strap_mode: assert property (p_strap_mode)
      else $error("operating mode strap not captured");

   property p_level_read;
      @(posedge clk) disable iff (rst)
         reg_rd && reg_addr == wlfs_pkg::input_level_status_addr
         |=> reg_rdata == {$past(development_mode_status), $past(pullup_config_status),
                           $past(pin_level), 1'b0, $past(wake_level)};
   endproperty
   a_level_read: assert property (p_level_read)
      else $error("input level read mismatch");

   property p_pin_hold;
      @(posedge clk) disable iff (rst)
         !normal_or_stop |=> $stable(pin_level);
   endproperty
   a_pin_hold: assert property (p_pin_hold)
      else $error("pin level changed outside normal or stop");

   property p_cyclic_hold;
      @(posedge clk) disable iff (rst)
         wake_cyclic[0] && !wake_sample_done[0] |=> wake_level[0] == $past(wake_level[0]);
   endproperty
   a_cyclic_hold: assert property (p_cyclic_hold)
      else $error("cyclic wake level moved without a sample");

   property p_switch_pin_shows;
      @(posedge clk) disable iff (rst)
         normal_or_stop && pin_selected[0] && pin_configured[0]
         |=> pin_level[0] == $past(pin_level_in[0]);
   endproperty
   a_switch_pin_shows: assert property (p_switch_pin_shows)
      else $error("pin 1 level not refreshed");

   property p_event_beats_clear;
      @(posedge clk) disable iff (rst)
         overload_event[2] && !soft_reset |=> overload_flags[2] [*1] ##0 overload_flags[2];
   endproperty
   a_event_beats_clear: assert property (p_event_beats_clear)
      else $error("overload event lost");

   property p_flag_sticky;
      @(posedge clk) disable iff (rst)
         open_load_flags[1] && !soft_reset &&
         !clr_hit(reg_clr, reg_addr, wlfs_pkg::switch_open_load_status_addr)
         |=> open_load_flags[1];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("open-load flag cleared without host command");

   property p_restart_keeps;
      @(posedge clk) disable iff (rst)
         restart && !soft_reset && !reg_clr
         |=> overload_flags == ($past(overload_flags) | $past(overload_event));
   endproperty
   a_restart_keeps: assert property (p_restart_keeps)
      else $error("restart disturbed fault flags");

   property p_id_read;
      @(posedge clk) disable iff (rst)
         reg_rd && reg_addr == wlfs_pkg::device_identification_addr
         |=> reg_rdata == {product_line_code, part_variant_code};
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("identification read mismatch");

   c_wake_read: cover property (@(posedge clk) disable iff (rst)
      pin_wake[0] ##1 reg_rd && reg_clr && reg_addr == wlfs_pkg::pin_wake_source_status_addr);
   c_set_on_clear: cover property (@(posedge clk) disable iff (rst)
      open_load_event[0] && clr_hit(reg_clr, reg_addr, wlfs_pkg::switch_open_load_status_addr));
   c_cyclic_sample: cover property (@(posedge clk) disable iff (rst)
      wake_cyclic[2] && wake_sample_done[2]);
   c_restart_flags: cover property (@(posedge clk) disable iff (rst)
      restart && overload_flags != 4'h0);
endmodule : wlfs_status_regs

// file: verification/wlfs_host_model.sv
// wlfs_host_model: host side of the command port, issuing reads and clears.
// assumes the status block answers with reg_rvalid a cycle after the read edge.
`timescale 1ns/1ps
module wlfs_host_model (
   input wire logic clk,
   output logic reg_rd,
   output logic reg_clr,
   output logic [6:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   // idle strobes from time zero
   initial begin
      reg_rd = 1'b0;
      reg_clr = 1'b0;
      reg_addr = 7'h00;
   end

   // one read, optionally clearing; apart from resets, flags only ever go away from here
   task automatic access(input logic [6:0] addr, input logic clr,
                         output logic [7:0] data, output int waits);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_clr <= clr;
      reg_addr <= addr;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_clr <= 1'b0;
      // a released address shows a fresh pattern so a stale decode is caught
      reg_addr <= ~addr;
      #1;
      waits = 1;
      while (reg_rvalid !== 1'b1 && waits < 4) begin
         @(posedge clk);
         #1;
         waits++;
      end
      data = reg_rdata;
   endtask : access
endmodule : wlfs_host_model

// file: verification/wake_level_fault_status_tb_top.sv
// wake_level_fault_status_tb_top: status group against a cycle model.
// assumes wlfs_pkg is compiled first and the host model drives the port.
`timescale 1ns/1ps
module wake_level_fault_status_tb_top;
   localparam logic [3:0] line_code = 4'h6; // arbitrary value
   localparam logic [3:0] variant_code = 4'h9; // arbitrary value
   logic clk, rst, soft_reset, restart, reg_rd, reg_clr, reg_rvalid, rand_on;
   logic fail_output3_test_pin, pullup_strap, normal_or_stop;
   logic [6:0] reg_addr;
   logic [7:0] reg_rdata, rdata;
   logic [1:0] pin_wake_event, failsafe_pin_wake, pin_level_in, pin_selected, pin_configured;
   logic [2:0] wake_level_in, wake_cyclic, wake_sample_done;
   logic [3:0] overload_event, open_load_event, m_ovl, m_ol;
   logic [1:0] m_wake, m_pin;
   logic [2:0] m_wk;
   logic m_dev, m_pull, m_pend;
   logic [7:0] exp_q[$];
   logic [6:0] addr_tab[6] = '{wlfs_pkg::pin_wake_source_status_addr,
      wlfs_pkg::input_level_status_addr, wlfs_pkg::switch_overload_status_addr,
      wlfs_pkg::switch_open_load_status_addr, wlfs_pkg::device_identification_addr, 7'h30};
   int mismatches = 0, check_count = 0, cycles = 0, waits;

   wlfs_status_regs #(.product_line_code(line_code), .part_variant_code(variant_code))
   wlfs_status_regs_i (.clk(clk), .rst(rst), .soft_reset(soft_reset), .restart(restart),
      .reg_rd(reg_rd), .reg_clr(reg_clr), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .pin_wake_event(pin_wake_event),
      .failsafe_pin_wake(failsafe_pin_wake), .fail_output3_test_pin(fail_output3_test_pin),
      .pullup_strap(pullup_strap), .pin_level_in(pin_level_in), .pin_selected(pin_selected),
      .pin_configured(pin_configured), .normal_or_stop(normal_or_stop),
      .wake_level_in(wake_level_in), .wake_cyclic(wake_cyclic),
      .wake_sample_done(wake_sample_done), .overload_event(overload_event),
      .open_load_event(open_load_event));

   wlfs_host_model wlfs_host_model_i (.clk(clk), .reg_rd(reg_rd), .reg_clr(reg_clr),
      .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic results;
      $display("comparisons %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results

   function automatic logic [7:0] model_read(input logic [6:0] a);
      case (a)
         wlfs_pkg::pin_wake_source_status_addr: return {2'h0, m_wake, 4'h0};
         wlfs_pkg::input_level_status_addr: return {m_dev, m_pull, m_pin, 1'h0, m_wk};
         wlfs_pkg::switch_overload_status_addr: return {4'h0, m_ovl};
         wlfs_pkg::switch_open_load_status_addr: return {4'h0, m_ol};
         wlfs_pkg::device_identification_addr: return {line_code, variant_code};
         default: return 8'h00;
      endcase
   endfunction : model_read

   function automatic bit hit(input logic [6:0] a);
      return reg_clr === 1'b1 && reg_addr === a;
   endfunction : hit

   // cycle model: inputs are read before this edge's updates land, so no race
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("unrequested answer", 8'h00, 8'h01);
         end else begin
            chk("read data", exp_q.pop_front(), reg_rdata);
         end
      end
      if (rst) begin
         {m_wake, m_ovl, m_ol, m_pin, m_wk, m_dev, m_pull} = '0;
         m_pend = 1'b1;
      end else begin
         if (reg_rd === 1'b1) exp_q.push_back(model_read(reg_addr));
         if (soft_reset) begin
            {m_wake, m_ovl, m_ol} = '0;
            m_pend = 1'b1;
         end else begin
            // set wins over a clear on the same edge
            m_wake = (hit(addr_tab[0]) ? 2'h0 : m_wake) | pin_wake_event | failsafe_pin_wake;
            m_ovl = (hit(addr_tab[2]) ? 4'h0 : m_ovl) | overload_event;
            m_ol = (hit(addr_tab[3]) ? 4'h0 : m_ol) | open_load_event;
            if (m_pend) {m_dev, m_pull, m_pend} = {fail_output3_test_pin, pullup_strap, 1'b0};
         end
         for (int i = 0; i < 2; i++) begin
            if (normal_or_stop && pin_selected[i] && pin_configured[i]) m_pin[i] = pin_level_in[i];
         end
         for (int i = 0; i < 3; i++) begin
            if (!wake_cyclic[i] || wake_sample_done[i]) m_wk[i] = wake_level_in[i];
         end
      end
   end

   // random stimulus; events are thinned out so that clears have something to show
   always @(posedge clk) begin
      if (rand_on) begin
         overload_event <= 4'($urandom & $urandom & $urandom);
         open_load_event <= 4'($urandom & $urandom & $urandom);
         pin_wake_event <= 2'($urandom & $urandom & $urandom);
         failsafe_pin_wake <= 2'($urandom & $urandom & $urandom);
         restart <= 1'($urandom & $urandom);
         pin_level_in <= 2'($urandom);
         pin_selected <= 2'($urandom);
         pin_configured <= 2'($urandom);
         normal_or_stop <= 1'($urandom);
         wake_level_in <= 3'($urandom);
         wake_cyclic <= 3'($urandom);
         wake_sample_done <= 3'($urandom);
      end
   end

   // hang guard, well above the roughly eight hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end

   task automatic pulse(input logic [3:0] ov, input logic [3:0] ol, input logic [1:0] wk,
                        input logic [1:0] fs);
      @(posedge clk);
      {overload_event, open_load_event, pin_wake_event, failsafe_pin_wake} <= {ov, ol, wk, fs};
      @(posedge clk);
      {overload_event, open_load_event, pin_wake_event, failsafe_pin_wake} <= '0;
   endtask : pulse

   task automatic rd_all(input logic clr);
      for (int a = 0; a < 6; a++) begin
         wlfs_host_model_i.access(addr_tab[a], clr, rdata, waits);
         chk("answer delay", 8'h01, 8'(waits));
      end
   endtask : rd_all

   // main sequence
   initial begin
      {soft_reset, restart, rand_on, pin_wake_event, failsafe_pin_wake} = '0;
      {pin_level_in, pin_selected, pin_configured, normal_or_stop} = '0;
      {wake_cyclic, wake_sample_done, overload_event, open_load_event} = '0;
      {rst, fail_output3_test_pin, pullup_strap, wake_level_in} = {3'b110, 3'h5};
      void'($urandom(99));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd_all(1'b1);
      for (int s = 0; s < 4; s++) begin
         pulse(4'(1 << s), 4'(8 >> s), 2'h0, 2'h0);
         rd_all(1'b0);
         rd_all(1'b1);
      end
      pulse(4'h0, 4'h0, 2'h2, 2'h1);
      rd_all(1'b1);
      fork
         wlfs_host_model_i.access(addr_tab[2], 1'b1, rdata, waits);
         pulse(4'h4, 4'h0, 2'h0, 2'h0);
      join
      pulse(4'ha, 4'h6, 2'h3, 2'h0);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      rd_all(1'b0);
      rand_on <= 1'b1;
      for (int n = 0; n < 300; n++) begin
         wlfs_host_model_i.access(addr_tab[$urandom % 6], 1'($urandom), rdata,
            waits);
      end
      rand_on <= 1'b0;
      @(posedge clk);
      {restart, normal_or_stop, pin_selected, pin_configured, wake_cyclic} <= {6'h1f, 3'h0};
      pulse(4'hf, 4'h5, 2'h3, 2'h0);
      {fail_output3_test_pin, pullup_strap, soft_reset} <= 3'b011;
      @(posedge clk);
      soft_reset <= 1'b0;
      repeat (2) @(posedge clk);
      rd_all(1'b0);
      // let the model see the last answer before the verdict, then nothing may be owed
      @(posedge clk);
      #1;
      chk("answers left over", 8'h00, 8'(exp_q.size()));
      results();
   end
endmodule : wake_level_fault_status_tb_top
